/* File: bus_matching_fifo.sv */
// port b bus matching, flag synchronisation, mailbox and ahb-lite registers
//
// What this block does
// [RULE_01] long-word mode: whole 36-bit word per read, lanes as written.
// [RULE_02] word mode: two reads on low 18 lines, order by endian.
// [RULE_03] byte mode: four reads on low 9 lines, order by endian.
// [RULE_04] word mode: upper 18 output lines carry no data.
// [RULE_05] byte mode: upper three byte lanes carry no data.
// [RULE_06] the system keeps bus match and size static; endian set at reset.
// [RULE_07] fall-through: output ready and first word load after a write.
// [RULE_08] standard: empty flag goes high after write into empty fifo.
// [RULE_09] sub-word modes: only last portion read lowers empty-side flags.
// [RULE_10] read from full fifo raises full / input ready on port a side.
// [RULE_11] sub-word modes: full-side skew counts from the last portion read.
// [RULE_12] almost-empty rises after fill passes threshold, port b timing.
// [RULE_13] almost-full rises after fill drops below threshold, port a timing.
// [RULE_14] depth is a parameter of 2048, 4096 or 8192 long words.
// [RULE_15] mailbox width narrows to 18 or 9 lines with port b size.
// [RULE_16] first portion from fifo, the rest from auxiliary storage.
// [RULE_17] endian select caught at reset release, fixed afterwards.
// [RULE_18] both fifo pointers cross ports through a two-stage synchroniser; mailbox flag updates cross directly.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module bus_matching_fifo
    import fifo_pkg::*;
#(
    parameter int unsigned DEPTH = 2048
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               portAClock,
    input  wire fifo_pkg::portAIn_t portAIn,
    input  wire logic               portBClock,
    input  wire fifo_pkg::portBIn_t portBIn,
    input  wire logic               bigEndianSelect,
    output var  logic [35:0]        portBData,
    output var  fifo_pkg::flags_t   flags,
    output var  logic               irq,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output var  logic               hreadyout,
    output var  logic [31:0]        hrdata,
    output var  logic               hresp
);
    import fifo_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [LEVEL_W-1:0] DEPTH_L = LEVEL_W'(DEPTH);

    logic [2:0] aClk_ff, bClk_ff;
    portAIn_t   aS1_ff, aS2_ff;
    portBIn_t   bS1_ff, bS2_ff;
    logic       beS1_ff, beS2_ff, bigEndian_ff, endianCaught_ff;
    logic       aRise, bRise;
    logic [AW:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [AW:0] rdSeenA1_ff, rdSeenA2_ff, wrSeenB1_ff, wrSeenB2_ff;
    logic [AW:0] nxt_rdSeenA1, nxt_rdSeenA2, nxt_wrSeenB1, nxt_wrSeenB2;
    logic [35:0] mail_ff, nxt_mail, aux_ff, nxt_aux, ramQ, nxt_portBData;
    logic [1:0]  portion_ff, nxt_portion, lastIdx;
    flags_t      nxt_flags, nxt_flagsB;
    logic [31:0] ctrl_ff, nxt_ctrl, offset_ff, nxt_offset, nxt_hrdata;
    logic [IRQ_W-1:0] irqStat_ff, nxt_irqStat, irqEn_ff, nxt_irqEn, events;
    logic [7:0]  dAddr_ff, nxt_dAddr;
    logic        dWrite_ff, nxt_dWrite, fifoWrite, mailWrite, mailTaken;
    logic        loadFirst, takeRead, retire, addrPhase;
    logic [LEVEL_W-1:0] levelA, levelB, ofsX, ofsY;
    busMode_t    mode;

    // select one portion of a long word for the port b lines
    function automatic logic [35:0] pickPortion(input logic [35:0] w, input busMode_t m,
                                                input logic be, input logic [1:0] p);
        logic [1:0] idx;
        pickPortion = '0;
        idx         = be ? ~p : p;
        case (m)
            LONG_MODE: pickPortion = w;
            WORD_MODE: pickPortion[HALF_W-1:0] = idx[0] ? w[35:18] : w[17:0];
            BYTE_MODE: pickPortion[BYTE_W-1:0] = w[BYTE_W*idx +: BYTE_W];
            default:   pickPortion = w;
        endcase
    endfunction

    fifo_ram #(.AW(AW)) u_ram (
        .clk    (clk),
        .wrEn   (fifoWrite),
        .wrAddr (wrPtr_ff[AW-1:0]),
        .wrData (aS2_ff.data),
        .rdAddr (rdPtr_ff[AW-1:0]),
        .rdData (ramQ)
    );

    // input synchronisers; data feeds logic from the second stage, clock edges from the second and third
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aClk_ff <= '0; bClk_ff <= '0; aS1_ff <= '0; aS2_ff <= '0;
            bS1_ff  <= '0; bS2_ff  <= '0;
            bigEndian_ff <= 1'b0; endianCaught_ff <= 1'b0;
        end
        else
        begin
            aClk_ff <= {aClk_ff[1:0], portAClock};
            bClk_ff <= {bClk_ff[1:0], portBClock};
            aS1_ff  <= portAIn; aS2_ff <= aS1_ff;
            bS1_ff  <= portBIn; bS2_ff <= bS1_ff;
            // [RULE_17] endian catch once
            if (!endianCaught_ff)
            begin
                bigEndian_ff    <= beS2_ff;
                endianCaught_ff <= 1'b1;
            end
        end
    end
    // endian strap synchroniser keeps sampling in reset, so release finds it settled
    always_ff @(posedge clk)
    begin
        beS1_ff <= bigEndianSelect;
        beS2_ff <= beS1_ff;
    end
    assign aRise = aClk_ff[1] & ~aClk_ff[2];
    assign bRise = bClk_ff[1] & ~bClk_ff[2];

    // mode decode; [RULE_06] software keeps these static
    always_comb
    begin
        mode = LONG_MODE;
        if (ctrl_ff[CTRL_BM_BIT])
        begin
            mode = ctrl_ff[CTRL_SIZE_BIT] ? BYTE_MODE : WORD_MODE;
        end
        case (mode)
            WORD_MODE: lastIdx = 2'd1;
            BYTE_MODE: lastIdx = 2'd3;
            default:   lastIdx = 2'd0;
        endcase
        ofsX = LEVEL_W'(offset_ff[OFS_X_LSB +: OFS_W]);
        ofsY = LEVEL_W'(offset_ff[OFS_Y_LSB +: OFS_W]);
    end

    // port b read side: portion sequencing and empty-side flags
    always_comb
    begin
        nxt_rdPtr = rdPtr_ff; nxt_aux = aux_ff; nxt_portion = portion_ff;
        nxt_portBData = portBData; nxt_wrSeenB1 = wrSeenB1_ff; nxt_wrSeenB2 = wrSeenB2_ff;
        nxt_flagsB = flags; loadFirst = 1'b0; takeRead = 1'b0; retire = 1'b0;
        mailTaken = bRise & bS2_ff.read & bS2_ff.mailSel;
        levelB = LEVEL_W'({wrSeenB2_ff - rdPtr_ff});  // pointer-width difference
        if (ctrl_ff[CTRL_FIRST_WORD_FALL_THROUGH_BIT])
        begin
            // [RULE_07] automatic load of the first portion
            loadFirst = bRise & ~flags.outputReadyFlag & (levelB != '0);
            takeRead  = bRise & bS2_ff.read & ~bS2_ff.mailSel & flags.outputReadyFlag;
        end
        else
        begin
            takeRead  = bRise & bS2_ff.read & ~bS2_ff.mailSel & flags.emptyFlagN;
            loadFirst = takeRead & (portion_ff == 2'd0);
        end
        if (loadFirst)
        begin
            // [RULE_16] whole word kept aside, first portion shown
            nxt_aux       = ramQ;
            nxt_portion   = 2'd0;
            nxt_portBData = pickPortion(ramQ, mode, bigEndian_ff, 2'd0);
            nxt_flagsB.outputReadyFlag = 1'b1;
        end
        // a read consumes the shown portion (fall-through) or the indexed one (standard)
        if (takeRead)
        begin
            retire      = portion_ff == lastIdx;
            nxt_portion = portion_ff + 2'd1;
        end
        if (takeRead && !loadFirst && !(retire && ctrl_ff[CTRL_FIRST_WORD_FALL_THROUGH_BIT]))
        begin
            // [RULE_02] [RULE_03] later portions from auxiliary storage
            nxt_portBData = pickPortion(aux_ff, mode, bigEndian_ff,
                                        ctrl_ff[CTRL_FIRST_WORD_FALL_THROUGH_BIT] ? nxt_portion : portion_ff);
        end
        if (retire)
        begin
            // [RULE_09] only the last portion retires the long word
            nxt_rdPtr   = rdPtr_ff + 1'b1;
            nxt_portion = 2'd0;
            nxt_flagsB.outputReadyFlag = 1'b0;
        end
        if (mailTaken)
        begin
            nxt_portBData = mail_ff;
        end
        if (bRise)
        begin
            // [RULE_18] write pointer through two port b stages
            nxt_wrSeenB1 = wrPtr_ff;
            nxt_wrSeenB2 = wrSeenB1_ff;
            // [RULE_08] [RULE_12] empty-side flags on port b edges
            nxt_flagsB.emptyFlagN       = LEVEL_W'({wrSeenB2_ff - nxt_rdPtr}) != '0;
            nxt_flagsB.almostEmptyFlagN = LEVEL_W'({wrSeenB2_ff - nxt_rdPtr}) > ofsX;
        end
    end

    // port a write side: pointer, full-side flags, mailbox
    always_comb
    begin
        nxt_wrPtr = wrPtr_ff; nxt_rdSeenA1 = rdSeenA1_ff; nxt_rdSeenA2 = rdSeenA2_ff;
        nxt_mail  = mail_ff;
        nxt_flags = nxt_flagsB;  // empty side from port b, full side refined below
        fifoWrite = aRise & aS2_ff.write & ~aS2_ff.mailSel & flags.fullFlagN;
        mailWrite = aRise & aS2_ff.write & aS2_ff.mailSel & flags.mailFullN;
        levelA    = '0;
        if (fifoWrite)
        begin
            nxt_wrPtr = wrPtr_ff + 1'b1;
        end
        if (aRise)
        begin
            // [RULE_11] [RULE_18] retired count through two port a stages
            nxt_rdSeenA1 = rdPtr_ff;
            nxt_rdSeenA2 = rdSeenA1_ff;
            levelA = LEVEL_W'({nxt_wrPtr - rdSeenA2_ff});
            // [RULE_10] [RULE_14] full and input ready
            nxt_flags.fullFlagN      = levelA != DEPTH_L;
            nxt_flags.inputReadyFlag = levelA != DEPTH_L;
            // [RULE_13] almost full against depth minus offset
            nxt_flags.almostFullFlagN = levelA < (DEPTH_L - ofsY);
        end
        if (mailTaken)
        begin
            nxt_flags.mailFullN = 1'b1;
        end
        if (mailWrite)
        begin
            // [RULE_15] mailbox narrowed to port b size
            case (mode)
                WORD_MODE: nxt_mail = {18'h0_0000, aS2_ff.data[HALF_W-1:0]};
                BYTE_MODE: nxt_mail = {27'h000_0000, aS2_ff.data[BYTE_W-1:0]};
                default:   nxt_mail = aS2_ff.data;
            endcase
            nxt_flags.mailFullN = 1'b0;
        end
    end

    // ahb-lite slave, zero wait, read data prepared in the address phase
    always_comb
    begin
        addrPhase  = hsel & hready & htrans[1];
        nxt_dWrite = addrPhase & hwrite;
        nxt_dAddr  = addrPhase ? haddr[7:0] : dAddr_ff;
        nxt_ctrl   = ctrl_ff; nxt_offset = offset_ff; nxt_irqEn = irqEn_ff;
        nxt_hrdata = hrdata;
        events = '0;
        events[IRQ_AE]   = flags.almostEmptyFlagN & ~nxt_flags.almostEmptyFlagN;
        events[IRQ_AF]   = flags.almostFullFlagN & ~nxt_flags.almostFullFlagN;
        events[IRQ_MAIL] = mailWrite;
        events[IRQ_OVF]  = aRise & aS2_ff.write & ~aS2_ff.mailSel & ~flags.fullFlagN;
        nxt_irqStat = irqStat_ff;
        if (dWrite_ff)
        begin
            case (dAddr_ff)
                ADDR_CTRL:    nxt_ctrl    = hwdata & 32'h0000_0007;
                ADDR_OFFSET:  nxt_offset  = hwdata & 32'h1FFF_1FFF;
                ADDR_IRQ_EN:  nxt_irqEn   = hwdata[IRQ_W-1:0];
                ADDR_IRQ_CLR: nxt_irqStat = irqStat_ff & ~hwdata[IRQ_W-1:0];
                default:      nxt_ctrl    = ctrl_ff;
            endcase
        end
        nxt_irqStat = nxt_irqStat | events;  // set wins over clear
        if (addrPhase && !hwrite)
        begin
            case (haddr[7:0])
                ADDR_CTRL:     nxt_hrdata = ctrl_ff;
                ADDR_OFFSET:   nxt_hrdata = offset_ff;
                ADDR_STATUS:   nxt_hrdata = {1'b0, levelB, 8'h00, bigEndian_ff,
                                             flags.mailFullN, flags.almostFullFlagN,
                                             flags.inputReadyFlag, flags.fullFlagN,
                                             flags.almostEmptyFlagN, flags.outputReadyFlag,
                                             flags.emptyFlagN};
                ADDR_IRQ_STAT: nxt_hrdata = 32'(irqStat_ff);
                ADDR_IRQ_EN:   nxt_hrdata = 32'(irqEn_ff);
                default:       nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_ff <= '0; rdPtr_ff <= '0; rdSeenA1_ff <= '0; rdSeenA2_ff <= '0;
            wrSeenB1_ff <= '0; wrSeenB2_ff <= '0; mail_ff <= '0; aux_ff <= '0;
            portion_ff <= '0; portBData <= '0; flags <= 7'h01;  // mailbox starts empty
            ctrl_ff <= CTRL_RESET; offset_ff <= OFFSET_RESET; irqStat_ff <= '0;
            irqEn_ff <= '0; irq <= 1'b0; dAddr_ff <= '0; dWrite_ff <= 1'b0;
            hrdata <= '0; hreadyout <= 1'b1; hresp <= 1'b0;
        end
        else
        begin
            wrPtr_ff <= nxt_wrPtr; rdPtr_ff <= nxt_rdPtr;
            rdSeenA1_ff <= nxt_rdSeenA1; rdSeenA2_ff <= nxt_rdSeenA2;
            wrSeenB1_ff <= nxt_wrSeenB1; wrSeenB2_ff <= nxt_wrSeenB2;
            mail_ff <= nxt_mail; aux_ff <= nxt_aux; portion_ff <= nxt_portion;
            portBData <= nxt_portBData; flags <= nxt_flags;
            ctrl_ff <= nxt_ctrl; offset_ff <= nxt_offset; irqStat_ff <= nxt_irqStat;
            irqEn_ff <= nxt_irqEn; irq <= |(nxt_irqStat & nxt_irqEn);
            dAddr_ff <= nxt_dAddr; dWrite_ff <= nxt_dWrite; hrdata <= nxt_hrdata;
            hreadyout <= 1'b1; hresp <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence fwftLoad;
        ctrl_ff[CTRL_FIRST_WORD_FALL_THROUGH_BIT] && !flags.outputReadyFlag && bRise && levelB != '0;
    endsequence
    sequence mailWordStore;
        mailWrite && mode == WORD_MODE;
    endsequence
    longWord_a: assert property (loadFirst && mode == LONG_MODE |=> portBData == $past(ramQ)) // [RULE_01]
        else $error("long word not passed whole");
    wordUpper_a: assert property (loadFirst && mode == WORD_MODE |=> portBData[35:18] == '0) // [RULE_04]
        else $error("word mode upper lines not idle");
    byteUpper_a: assert property (loadFirst && mode == BYTE_MODE |=> portBData[35:9] == '0) // [RULE_05]
        else $error("byte mode upper lanes not idle");
    lastRetire_a: assert property ($changed(rdPtr_ff) |-> $past(portion_ff == lastIdx)) // [RULE_09]
        else $error("long word retired before last portion");
    fwftReady_a: assert property (fwftLoad |=> flags.outputReadyFlag) // [RULE_07]
        else $error("output ready missed first word");
    syncStep_a: assert property ($changed(wrSeenB2_ff) |-> $past(bRise)) // [RULE_18]
        else $error("write pointer crossed outside port b edge");
    fullRise_a: assert property (aRise && !flags.fullFlagN && levelA != DEPTH_L |=> flags.fullFlagN) // [RULE_10]
        else $error("full flag did not clear");
    mailNarrow_a: assert property (mailWordStore |=> mail_ff[35:18] == '0) // [RULE_15]
        else $error("mailbox kept lines above word size");
    emptyRise_a: assert property (bRise && !ctrl_ff[CTRL_FIRST_WORD_FALL_THROUGH_BIT] && wrSeenB2_ff != nxt_rdPtr |=> flags.emptyFlagN) // [RULE_08]
        else $error("empty flag stayed low");
endmodule
`default_nettype wire

/* File: fifo_pkg.sv */
// constants, modes and carrier types of both ports of the bus-matching fifo
package fifo_pkg;
    localparam int DATA_W  = 36;
    localparam int HALF_W  = 18;
    localparam int BYTE_W  = 9;
    localparam int LEVEL_W = 15;
    localparam int OFS_W   = 13;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_OFFSET   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
    // control fields
    localparam int CTRL_BM_BIT   = 0;
    localparam int CTRL_SIZE_BIT = 1;
    localparam int CTRL_FIRST_WORD_FALL_THROUGH_BIT = 2;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam int OFS_X_LSB = 0;
    localparam int OFS_Y_LSB = 16;
    localparam logic [31:0] OFFSET_RESET = 32'h0008_0008;
    // status fields
    localparam int ST_EMPTY_N = 0;
    localparam int ST_OR      = 1;
    localparam int ST_AE_N    = 2;
    localparam int ST_FULL_N  = 3;
    localparam int ST_IR      = 4;
    localparam int ST_AF_N    = 5;
    localparam int ST_MAIL_N  = 6;
    localparam int ST_BE      = 7;
    localparam int ST_LVL_LSB = 16;
    // interrupt event bits
    localparam int IRQ_W    = 4;
    localparam int IRQ_AE   = 0;
    localparam int IRQ_AF   = 1;
    localparam int IRQ_MAIL = 2;
    localparam int IRQ_OVF  = 3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {LONG_MODE, WORD_MODE, BYTE_MODE} busMode_t;

    typedef struct packed {
        logic              write;
        logic              mailSel;
        logic [DATA_W-1:0] data;
    } portAIn_t;

    typedef struct packed {
        logic read;
        logic mailSel;
    } portBIn_t;

    typedef struct packed {
        logic emptyFlagN;
        logic outputReadyFlag;
        logic almostEmptyFlagN;
        logic fullFlagN;
        logic inputReadyFlag;
        logic almostFullFlagN;
        logic mailFullN;
    } flags_t;
endpackage

/* File: fifo_ram.sv */
// long-word fifo storage with a registered read port
`timescale 1ns/1ns
`default_nettype none
module fifo_ram #(
    parameter int AW = 11
) (
    input  wire logic          clk,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [35:0]   wrData,
    input  wire logic [AW-1:0] rdAddr,
    output var  logic [35:0]   rdData
);
    logic [35:0] mem [2**AW];

    // write and registered read
    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

/* File: port_partner.sv */
// port a writer and port b reader, each clocked by its own link clock
`timescale 1ns/1ns
`default_nettype none
module port_partner
    import fifo_pkg::*;
(
    output var logic               portAClock,
    output var fifo_pkg::portAIn_t portAIn,
    output var logic               portBClock,
    output var fifo_pkg::portBIn_t portBIn
);
    // free-running 320 ns port clocks, phases unrelated to clk and each other
    initial
    begin
        portAClock = 1'b0;
        portBClock = 1'b0;
        portAIn    = '0;
        portBIn    = '0;
        fork
            begin
                #7;
                forever #160 portAClock = ~portAClock;
            end
            begin
                #53;
                forever #160 portBClock = ~portBClock;
            end
        join
    end

    // one write taken at the next port a rising edge; driven on the falling
    // edge so the sampled data never races the sampled clock
    task automatic writeA(input logic [35:0] d, input logic mail);
        @(negedge portAClock);
        portAIn <= '{write: 1'b1, mailSel: mail, data: d};
        @(negedge portAClock);
        portAIn.write <= 1'b0;
        portAIn.data  <= ~d;  // released bus shows no stale word
    endtask

    // n reads on consecutive port b rising edges
    task automatic readB(input logic mail, input int n);
        @(negedge portBClock);
        portBIn <= '{read: 1'b1, mailSel: mail};
        repeat (n) @(negedge portBClock);
        portBIn.read <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: test_bus_matching_fifo.sv */
// self-checking bench for the bus-matching fifo port a and port b sides
`timescale 1ns/1ns
`default_nettype none
module test_bus_matching_fifo
    import fifo_pkg::*;
;
    typedef struct packed {logic [35:0] exp; logic [35:0] mask;} note_t;
    localparam int I_EMPTY = 6;
    localparam int I_READY = 5;
    localparam int I_ALMEMPTY = 4;
    localparam int I_FULL = 3;
    localparam int I_ALMFULL = 1;
    localparam int I_MAIL = 0;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        bigEndianSelect = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, irq, portAClock, portBClock;
    logic [35:0] portBData;
    portAIn_t    portAIn;
    portBIn_t    portBIn;
    flags_t      flags;
    note_t       notes[$];
    logic [35:0] sent[$];
    int          errors = 0;
    int          checked = 0;
    int          part = 0;

    always #20 clk = ~clk;

    bus_matching_fifo #(.DEPTH(2048)) u_dut (
        .clk(clk), .rst_n(rst_n), .portAClock(portAClock), .portAIn(portAIn),
        .portBClock(portBClock), .portBIn(portBIn), .bigEndianSelect(bigEndianSelect),
        .portBData(portBData), .flags(flags), .irq(irq), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
    );

    port_partner u_partner (
        .portAClock(portAClock), .portAIn(portAIn),
        .portBClock(portBClock), .portBIn(portBIn)
    );

    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // number of reads per long word in a mode
    function automatic int parts(input int m);
        return (m == 0) ? 1 : (m == 1) ? 2 : 4;
    endfunction

    // portion k of a long word and the output lanes that carry it
    function automatic note_t portion(input logic [35:0] w, input int m, input logic bigEnd,
                                      input int k);
        int j;
        j = bigEnd ? parts(m) - 1 - k : k;
        if (m == 0)
            return '{w, 36'hF_FFFF_FFFF};
        if (m == 1)
            return '{36'(w[18*j +: 18]), 36'h0_0003_FFFF};
        return '{36'(w[9*j +: 9]), 36'h0_0000_01FF};
    endfunction

    // one single ahb-lite transfer, waiting on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= 32'(a);
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 36'(hresp), '0);
    endtask

    task automatic regCheck(input string name, input logic [7:0] a, input logic [31:0] mask,
                            input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, '0, rd);
        check(name, 36'(rd & mask), 36'(exp));
    endtask

    task automatic waitBit(input string name, input int idx, input logic val);
        int i;
        for (i = 0; i < 48 && flags[idx] !== val; i++)
            @(posedge clk);
        check(name, 36'(flags[idx]), 36'(val));
    endtask

    task automatic doReset(input logic bigEnd, input int m, input logic fall);
        logic [31:0] rd;
        @(posedge clk);
        rst_n           <= 1'b0;
        bigEndianSelect <= bigEnd;
        repeat (3) @(posedge clk);
        check("flags in reset", 36'(flags), 36'h0_0000_0001);
        rst_n <= 1'b1;
        sent.delete();
        part = 0;
        repeat (40) @(posedge clk);
        check("flags after reset", 36'(flags), 36'h0_0000_000F);
        regCheck("ctrl reset", ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
        regCheck("offset reset", ADDR_OFFSET, 32'hFFFF_FFFF, OFFSET_RESET);
        ahb(1'b1, ADDR_CTRL, {29'h0000_0000, fall, m == 2, m != 0}, rd);
        regCheck("endian", ADDR_STATUS, 32'h0000_0080, 32'(bigEnd) << ST_BE);
        bigEndianSelect <= ~bigEnd;  // later changes must be ignored
    endtask

    task automatic putWord();
        logic [35:0] w;
        w = 36'({$urandom(), $urandom()});
        sent.push_back(w);
        u_partner.writeA(w, 1'b0);
    endtask

    // queue the expected portions, then read them on consecutive edges
    task automatic readParts(input int m, input logic bigEnd, input int cnt);
        int k;
        if (cnt == 0)
            return;
        for (k = 0; k < cnt; k++)
        begin
            notes.push_back(portion(sent[0], m, bigEnd, part));
            part++;
            if (part == parts(m))
            begin
                part = 0;
                sent.delete(0);
            end
        end
        u_partner.readB(1'b0, cnt);
        repeat (8) @(posedge clk);
    endtask

    // two long words written, then read: all but the last portion back to back, crossing the word boundary in word and byte modes
    task automatic sendWord(input int m, input logic bigEnd);
        putWord();
        putWord();
        waitBit("empty rise", I_EMPTY, 1'b1);
        readParts(m, bigEnd, 2 * parts(m) - 1);
        check("empty held", 36'(flags[I_EMPTY]), 36'h0_0000_0001);
        readParts(m, bigEnd, 1);
        check("empty flags low", 36'(flags[6:4]), '0);
    endtask

    // compares port b data after each read edge with the oldest note
    // lane order
    always @(posedge portBClock)
    begin
        if (portBIn.read === 1'b1 && notes.size() > 0)
        begin
            repeat (5) @(posedge clk);
            check("port b data", portBData & notes[0].mask, notes[0].exp);
            notes.delete(0);
        end
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        finish_test();
    end

    initial
    begin
        logic [31:0] rd;
        logic [35:0] w;
        void'($urandom(41840));
        for (int b = 0; b < 2; b++)
            for (int m = 0; m < 3; m++)
            begin
                doReset(1'(b), m, 1'b0);
                sendWord(m, 1'(b));
            end
        // mail write with its interrupt raised, masked and cleared
        doReset(1'b1, 1, 1'b0);
        ahb(1'b1, ADDR_IRQ_EN, 32'h0000_0004, rd);
        w = 36'({$urandom(), $urandom()});
        u_partner.writeA(w, 1'b1);
        waitBit("mail full", I_MAIL, 1'b0);
        repeat (4) @(posedge clk);
        check("irq raised", 36'(irq), 36'h0_0000_0001);
        notes.push_back('{36'(w[17:0]), 36'h0_0003_FFFF});
        u_partner.readB(1'b1, 1);
        waitBit("mail read", I_MAIL, 1'b1);
        ahb(1'b1, ADDR_IRQ_EN, '0, rd);
        repeat (4) @(posedge clk);
        check("irq masked", 36'(irq), '0);
        ahb(1'b1, ADDR_IRQ_CLR, 32'h0000_000F, rd);
        regCheck("irq cleared", ADDR_IRQ_STAT, 32'h0000_0004, '0);
        regCheck("clear reads zero", ADDR_IRQ_CLR, 32'hFFFF_FFFF, '0);
        regCheck("unmapped", 8'h40, 32'hFFFF_FFFF, '0);
        doReset(1'b0, 1, 1'b1);
        w = 36'({$urandom(), $urandom()});
        u_partner.writeA(w, 1'b0);
        waitBit("ready rise", I_READY, 1'b1);
        repeat (2) @(posedge clk);
        check("fall through", portBData & 36'h0_0003_FFFF, 36'(w[17:0]));
        notes.push_back('{36'(w[35:18]), 36'h0_0003_FFFF});
        notes.push_back('{'0, '0});
        u_partner.readB(1'b0, 2);
        repeat (8) @(posedge clk);
        check("ready fall", 36'(flags[I_READY]), '0);
        // fill to depth in byte mode, then free nine long words byte by byte
        doReset(1'b1, 2, 1'b0);
        for (int i = 1; i <= 2048; i++)
        begin
            putWord();
            if (i == 8 || i == 9)
            begin
                repeat (24) @(posedge clk);
                check("almost empty", 36'(flags[I_ALMEMPTY]), 36'(i == 9));
            end
        end
        repeat (24) @(posedge clk);
        check("full", 36'(flags[I_FULL]), '0);
        readParts(2, 1'b1, 3);
        repeat (16) @(posedge clk);
        check("full held", 36'(flags[I_FULL]), '0);
        readParts(2, 1'b1, 1);
        waitBit("full freed", I_FULL, 1'b1);
        readParts(2, 1'b1, 28);
        repeat (16) @(posedge clk);
        check("almost full held", 36'(flags[I_ALMFULL]), '0);
        readParts(2, 1'b1, 4);
        waitBit("almost full freed", I_ALMFULL, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
